// ### hdl/rtes_pkg.sv
// Package for the transmit enable sequencer: states, timing and carriers.
package rtes_pkg;

  // Core clock period in picoseconds (200 MHz).
  localparam int CORE_CLK_PS = 5000;
  // Oscillator and synthesizer settling time, in microseconds.
  localparam int SETTLE_US = 1000;
  // Settling time in core clock cycles, a least time rounded up.
  localparam int SETTLE_CYCLES = (SETTLE_US * 1000000 + CORE_CLK_PS - 1)
    / CORE_CLK_PS;
  // Width of the settle counter.
  localparam int SETTLE_W = 20;
  // Crystal clock divide ratio for the delivered clock.
  localparam int CLK_DIV = 4;
  // Width of the divider counter.
  localparam int DIV_W = 2;
  // One in the divider counter width.
  localparam logic [DIV_W-1:0] DIV_ONE = 2'h1;
  // Reset value of the divider counter.
  localparam logic [DIV_W-1:0] DIV_RST = 2'h0;
  // Carrier frequency code when the keying switch is open.
  localparam logic FREQ_HIGH = 1'b1;
  // Carrier frequency code when the keying switch is closed.
  localparam logic FREQ_LOW = 1'b0;

  // Operating states, Gray coded along standby, settle, ready, transmit.
  typedef enum logic [1:0] {
    RTES_STANDBY = 2'h0,
    RTES_SETTLE = 2'h1,
    RTES_READY = 2'h3,
    RTES_TRANSMIT = 2'h2
  } rtes_state_t;

  // Enable pins from the controller.
  typedef struct packed {
    logic main_enable;
    logic amp_switch_in;
  } rtes_enables_t;

  // Analog block controls driven by the sequencer.
  typedef struct packed {
    logic crystal_osc_on;
    logic synth_on;
    logic clk_driver_on;
    logic amp_on;
  } rtes_power_t;

endpackage

// ### hdl/rtes_sequencer.sv
// Transmit enable sequencer for an integrated UHF transmitter.
`timescale 1ns/1ps

// Notes on behaviour
// - Both enables low: everything off, standby.
// - Main enable high: oscillator, synthesizer, clock driver on.
// - Amp switch low: clock delivered, amplifier off.
// - Amp switch keys the amplifier: ASK modulation.
// - Switch closed gives lower carrier frequency.
// - Delivered clock runs at crystal over four.
module rtes_sequencer
#(
  parameter int SETTLE_COUNT = rtes_pkg::SETTLE_CYCLES
)
(
  // Core clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST,
  // Crystal oscillator clock, the link domain.
  input wire logic XTAL_CLK,
  // Enable pins from the controller.
  input wire rtes_pkg::rtes_enables_t ENABLES,
  // Load capacitor switch state, high when closed.
  input wire logic FSK_SWITCH_CLOSED,
  // Analog block controls.
  output rtes_pkg::rtes_power_t POWER,
  // Carrier frequency select, low when the switch is closed.
  output logic FREQ_SEL,
  // Delivered clock to the controller.
  output logic CLK_OUT,
  // Settling time elapsed and clock stable.
  output logic CLK_STABLE,
  // Current operating state.
  output rtes_pkg::rtes_state_t STATE
);
  import rtes_pkg::*;

  // Pin synchronisers in the core domain.
  logic main_s1_q, main_s2_q, amp_s1_q, amp_s2_q, fsk_s1_q, fsk_s2_q;
  // Core state.
  rtes_state_t state_q, state_d;
  logic [SETTLE_W-1:0] settle_q, settle_d;
  rtes_power_t power_q, power_d;
  logic freq_q, freq_d;
  // Link domain: clock driver enable crossing and divider.
  logic drv_s1_q, drv_s2_q;
  logic [DIV_W-1:0] div_q, div_d;
  logic clk_out_q, clk_out_d;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      main_s1_q <= 1'b0;
      main_s2_q <= 1'b0;
      amp_s1_q <= 1'b0;
      amp_s2_q <= 1'b0;
      fsk_s1_q <= 1'b0;
      fsk_s2_q <= 1'b0;
    end
    else
    begin
      main_s1_q <= ENABLES.main_enable;
      main_s2_q <= main_s1_q;
      amp_s1_q <= ENABLES.amp_switch_in;
      amp_s2_q <= amp_s1_q;
      fsk_s1_q <= FSK_SWITCH_CLOSED;
      fsk_s2_q <= fsk_s1_q;
    end
  end

  always_comb
  begin
    state_d = state_q;
    settle_d = settle_q;
    power_d = '0;
    freq_d = fsk_s2_q ? FREQ_LOW : FREQ_HIGH;
    if (!main_s2_q)
    begin
      state_d = RTES_STANDBY;
      settle_d = '0;
    end
    else
    begin
      power_d.crystal_osc_on = 1'b1;
      power_d.synth_on = 1'b1;
      power_d.clk_driver_on = 1'b1;
      power_d.amp_on = amp_s2_q;
      case (state_q)
        RTES_STANDBY:
        begin
          state_d = RTES_SETTLE;
          settle_d = '0;
        end
        RTES_SETTLE:
        begin
          if (settle_q >= SETTLE_W'(SETTLE_COUNT - 1))
          begin
            state_d = RTES_READY;
          end
          else
          begin
            settle_d = settle_q + 1'b1;
          end
        end
        RTES_READY:
        begin
          if (amp_s2_q)
          begin
            state_d = RTES_TRANSMIT;
          end
        end
        RTES_TRANSMIT:
        begin
          if (!amp_s2_q)
          begin
            state_d = RTES_READY;
          end
        end
        default:
        begin
          state_d = RTES_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= RTES_STANDBY;
      settle_q <= '0;
      power_q <= '0;
      freq_q <= FREQ_HIGH;
    end
    else
    begin
      state_q <= state_d;
      settle_q <= settle_d;
      power_q <= power_d;
      freq_q <= freq_d;
    end
  end

  // Divider on the crystal clock; the driver enable crosses in by two flops.
  always_comb
  begin
    div_d = div_q + DIV_ONE;
    clk_out_d = clk_out_q;
    if (!drv_s2_q)
    begin
      div_d = DIV_RST;
      clk_out_d = 1'b0;
    end
    else if (div_q == DIV_W'(CLK_DIV / 2 - 1))
    begin
      div_d = DIV_RST;
      clk_out_d = ~clk_out_q;
    end
  end

  always_ff @(posedge XTAL_CLK or posedge RST)
  begin
    if (RST)
    begin
      drv_s1_q <= 1'b0;
      drv_s2_q <= 1'b0;
      div_q <= DIV_RST;
      clk_out_q <= 1'b0;
    end
    else
    begin
      drv_s1_q <= power_q.clk_driver_on;
      drv_s2_q <= drv_s1_q;
      div_q <= div_d;
      clk_out_q <= clk_out_d;
    end
  end

  assign POWER = power_q;
  assign FREQ_SEL = freq_q;
  assign CLK_OUT = clk_out_q;
  assign CLK_STABLE = (state_q == RTES_READY) || (state_q == RTES_TRANSMIT);
  assign STATE = state_q;

endmodule

// ### verif/rtes_monitor.sv
// Checker for the sequencer ports.
`timescale 1ns/1ps
module rtes_monitor
#(parameter int SETTLE_COUNT = 20)
(
  // Sequencer ports.
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic XTAL_CLK,
  input wire rtes_pkg::rtes_enables_t ENABLES,
  input wire logic FSK_SWITCH_CLOSED,
  input wire rtes_pkg::rtes_power_t POWER,
  input wire logic FREQ_SEL,
  input wire logic CLK_OUT,
  input wire logic CLK_STABLE,
  input wire rtes_pkg::rtes_state_t STATE
);
  import rtes_pkg::*;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  AST_OFF: assert property (!ENABLES[1] [*4] |=> POWER == 4'h0)
    else $error("not off");
  AST_ON: assert property (ENABLES[1] [*4] |=> POWER[3:1] == 3'h7)
    else $error("not on");
  AST_AMPOFF: assert property (ENABLES == 2'h2 [*4] |=> !POWER[0])
    else $error("amp on");
  AST_AMPON: assert property (ENABLES == 2'h3 [*4] |=> POWER[0])
    else $error("amp off");
  AST_FSK: assert property (FSK_SWITCH_CLOSED [*4] |=> !FREQ_SEL)
    else $error("freq high");
  AST_SETTLE: assert property ($rose(CLK_STABLE) |->
    $past(STATE, SETTLE_COUNT) == RTES_SETTLE) else $error("settle short");
  AST_CLKOFF: assert property (@(posedge XTAL_CLK) disable iff (RST)
    !POWER[1] [*4] |=> !CLK_OUT) else $error("clock runs");
  AST_DIV: assert property (@(posedge XTAL_CLK) disable iff (RST)
    $rose(CLK_OUT) ##3 POWER[1] |-> $past(CLK_OUT, 2) && !CLK_OUT)
    else $error("bad divide");
  cover property (STATE == RTES_TRANSMIT);
  cover property ($rose(CLK_STABLE));
  cover property (POWER[0] && !FREQ_SEL);
endmodule
bind rtes_sequencer rtes_monitor #(.SETTLE_COUNT(SETTLE_COUNT)) mon_inst (.*);

// ### verif/rtes_ctrl_model.sv
// Controller model that drives the enable pins and keying switch.
`timescale 1ns/1ps
module rtes_ctrl_model
(
  // Controller pins.
  input wire logic clk,
  output rtes_pkg::rtes_enables_t enables,
  output logic fsk_closed
);
  initial
  begin
    enables = 2'h0;
    fsk_closed = 1'b0;
  end
  // Sets main enable, amp switch and keying switch, then holds n cycles.
  task automatic pins(input logic m, input logic a, input logic f,
    input int n);
    @(posedge clk) #1 enables = {m, a};
    fsk_closed = f;
    repeat (n) @(posedge clk);
    #1;
  endtask
endmodule

// ### verif/rtes_sequencer_tb_top.sv
// Testbench for the transmit enable sequencer.
`timescale 1ns/1ps
module rtes_sequencer_tb_top;
  import rtes_pkg::*;
  localparam int SC = 20;
  logic clk = 1'b0, xclk = 1'b0, rst = 1'b1, fsk, fq, co, stb;
  rtes_enables_t en;
  rtes_power_t pw;
  rtes_state_t st;
  int err_total = 0, num_checks = 0;
  initial forever #2.5 clk = ~clk;
  initial #7 forever #24 xclk = ~xclk;
  rtes_sequencer #(.SETTLE_COUNT(SC)) rtes_sequencer_inst (.CORE_CLK(clk),
    .RST(rst), .XTAL_CLK(xclk), .ENABLES(en), .FSK_SWITCH_CLOSED(fsk),
    .POWER(pw), .FREQ_SEL(fq), .CLK_OUT(co), .CLK_STABLE(stb), .STATE(st));
  rtes_ctrl_model rtes_ctrl_model_inst (.clk(clk), .enables(en),
    .fsk_closed(fsk));
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Compares a measured period of the delivered clock.
  task automatic chk_t(input realtime g, input realtime e);
    num_checks++;
    if (g != e)
    begin
      err_total++;
      $display("unexpected at %0t: period %0t want %0t", $time, g, e);
    end
  endtask
  task automatic chk_st(input rtes_state_t g, input rtes_state_t e);
    chk({2'h0, g}, {2'h0, e});
  endtask
  task automatic p(input logic m, a, f, input int n);
    rtes_ctrl_model_inst.pins(m, a, f, n);
  endtask
  task automatic off();
    p(1, 0, 0, 8);
    chk(pw, 4'he);
    p(0, 0, 0, 8);
    chk(pw, 4'h0);
    chk_st(st, RTES_STANDBY);
  endtask
  task automatic t_abort();
    p(1, 0, 0, 8);
    chk(pw, 4'he);
    chk_st(st, RTES_SETTLE);
    chk(stb, 0);
    p(0, 1, 0, 8);
    chk(pw, 4'h0);
    $display("abort done");
  endtask
  task automatic t_ask();
    realtime t0;
    p(1, 0, 0, SC + 8);
    chk_st(st, RTES_READY);
    chk(stb, 1);
    @(posedge co);
    t0 = $realtime;
    @(posedge co);
    chk_t($realtime - t0, CLK_DIV * 48.0);
    for (int i = 1; i < 5; i++)
    begin
      p(1, i[0], 0, 8);
      chk(pw, {3'h7, i[0]});
    end
    chk_st(st, RTES_READY);
    off();
    $display("ask done");
  endtask
  task automatic t_fsk();
    p(1, 0, 0, SC + 8);
    for (int i = 0; i < 4; i++)
    begin
      p(1, 1, i[0], 8);
      chk(fq, !i[0]);
      chk_st(st, RTES_TRANSMIT);
    end
    off();
    $display("fsk done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_abort();
    t_ask();
    t_fsk();
    wrap_up();
  end
  initial
  begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule
